// ==== src/cif_cache.sv ====
// Purpose: Cache end: invalidation sequencing, miss fetch and fill buffer.
// Assumes: One request held until f_done; memory answers with EXT_ACK.
// Notes:   Tag and data arrays are not reset, so startup must invalidate.
// Behaviour
// - No snooping of writes for instruction coherency.
// - Invalidate-all clears one tag per cycle, 128.
// - Split mode: half selects qualify invalidate-all.
// - Fetches stall until invalidation sequence ends.
// - Line invalidate at bits 10:4 unless disabled.
// - Software sets bit 10 to pick half.
// - Reset clears control, keeps tag contents.
// - Startup invalidates before first enabling cache.
// - Cacheable double miss fetches; data gets line.
// - Instruction fetch size from fill-size field.
// - Software may choose fill sizes 00 or 01.
// - Line fill starts at critical longword, wraps.
// - Miss loading fill buffer sets recent indicator.
// - Array access at buffer index clears indicator.
// - Next miss copies full, recent buffer in.
// - Unbuffered odd word branch gives word-sized fetch.
// - Buffered noncacheable instructions never enter array.
// - Enable clear: all instruction fetches single-sized.
// - No buffering bit: noncacheable fetches single, unbuffered.
// - Control registers need supervisor, codes 2,4,5.
// - Unassigned codes, reserved bits ignored, read zero.
// - Write-only reads zero; read-only writes ignored.
// - Buffer valid per longword, early words hit.
`timescale 1ns/1ps
`default_nettype none
`include "cif_params.svh"
module cif_cache (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  // Core local bus.
  cif_if.dev               LB,
  // External memory bus.
  output logic             EXT_REQ,
  output logic [31:0]      EXT_ADDR,
  output logic             EXT_LONG,
  output logic             EXT_BURST,
  input  wire logic        EXT_ACK,
  input  wire logic [31:0] EXT_RDATA
);
  // ----------------------------------------------------------------------
  // State and arrays
  // ----------------------------------------------------------------------
  cif_pkg::cif_dev_t s_q, s_d;
  logic              tag_v    [0:127];
  logic [21:0]       tag_a    [0:127];
  logic [3:0][31:0]  data_mem [0:127];
  logic              split, en, hit_arr, hit_fb, cach, nc_buf, line_sz, fb_full;
  logic              copy_we, clr_we, cmd_ok;
  logic [6:0]        req_idx, fb_idx, clr_idx;
  logic [1:0]        fill_sz;

  // Configuration and lookup of the current request.
  always_comb begin
    split   = !s_q.ctrl[`CIF_B_DIS_INSTR] && !s_q.ctrl[`CIF_B_DIS_DATA];
    en      = s_q.ctrl[`CIF_B_ENABLE];
    fill_sz = s_q.ctrl[`CIF_B_FILL_HI:`CIF_B_FILL_LO];
    req_idx = split ? {LB.f_instr, LB.f_addr[9:4]} : LB.f_addr[10:4];
    fb_idx  = split ? {s_q.fb_instr, s_q.fb_line[5:0]} : s_q.fb_line[6:0];
    fb_full = &s_q.fb_vld;
    // The disabled side of a single-purpose cache is treated as noncacheable.
    cach    = en && LB.f_cache
              && !(LB.f_instr ? s_q.ctrl[`CIF_B_DIS_INSTR] : s_q.ctrl[`CIF_B_DIS_DATA]);
    nc_buf  = en && LB.f_instr && !cach && s_q.ctrl[`CIF_B_NC_BUF];
    hit_arr = cach && tag_v[req_idx]
              && (split ? tag_a[req_idx] == LB.f_addr[31:10]
                        : tag_a[req_idx][21:1] == LB.f_addr[31:11]);
    hit_fb  = en && s_q.fb_line == LB.f_addr[31:4] && s_q.fb_instr == LB.f_instr
              && s_q.fb_vld[LB.f_addr[3:2]];
    // Data misses always take a line; instructions follow the fill-size field.
    line_sz = 1'b1;
    if (LB.f_instr) begin
      case (fill_sz)
        2'b00:   line_sz = LB.f_addr[3:2] != 2'b11;
        2'b01:   line_sz = !LB.f_addr[3];
        default: line_sz = 1'b1;
      endcase
    end
    cmd_ok  = LB.ctl_wr && LB.ctl_super;
  end

  // Main sequencer: control writes, invalidation, lookups and fills.
  always_comb begin
    s_d     = s_q;
    s_d.done = 1'b0;
    copy_we = 1'b0;
    clr_we  = 1'b0;
    clr_idx = s_q.inv_cnt;
    // Unknown codes and reserved bits are dropped; invalidate-all never stores.
    if (cmd_ok) begin
      case (LB.ctl_code)
        `CIF_CODE_CTRL: begin
          s_d.ctrl = LB.ctl_wdata & `CIF_CTRL_MASK;
          if (LB.ctl_wdata[`CIF_B_INV_ALL]) begin
            s_d.inv_pend = 1'b1;
            s_d.inv_cnt  = 7'h00;
            s_d.inv_last = `CIF_LAST_ENTRY;
            if (!LB.ctl_wdata[`CIF_B_DIS_INSTR] && !LB.ctl_wdata[`CIF_B_DIS_DATA]) begin
              if (LB.ctl_wdata[`CIF_B_INV_INSTR] && !LB.ctl_wdata[`CIF_B_INV_DATA]) begin
                s_d.inv_cnt = `CIF_HALF_FIRST;
              end else if (LB.ctl_wdata[`CIF_B_INV_DATA]
                           && !LB.ctl_wdata[`CIF_B_INV_INSTR]) begin
                s_d.inv_last = `CIF_HALF_LAST;
              end
            end
          end
        end
        `CIF_CODE_WIN0: s_d.win0 = LB.ctl_wdata;
        `CIF_CODE_WIN1: s_d.win1 = LB.ctl_wdata;
        default: ;
      endcase
    end
    case (s_q.state)
      // Pending invalidation goes first, so no fetch is served before it.
      cif_pkg::ST_IDLE: begin
        if (s_q.inv_pend) begin
          s_d.state    = cif_pkg::ST_INVAL;
          s_d.inv_pend = 1'b0;
          s_d.fb_vld   = 4'h0;
        end else if (LB.f_req && !s_q.done && !hit_fb && !hit_arr) begin
          // Retire a complete, newer buffer before it is overwritten.
          copy_we = fb_full && s_q.fb_mru && !s_q.fb_nc;
          if (cach || nc_buf) begin
            s_d.state     = cif_pkg::ST_FILL;
            s_d.fb_line   = LB.f_addr[31:4];
            s_d.fb_instr  = LB.f_instr;
            s_d.fb_nc     = !cach;
            s_d.fb_mru    = 1'b1;
            s_d.fb_vld    = 4'h0;
            s_d.crit      = LB.f_addr[3:2];
            s_d.beat      = 2'h0;
            s_d.last_beat = line_sz ? 2'h3 : 2'h0;
            s_d.ext_req   = 1'b1;
            s_d.ext_addr  = {LB.f_addr[31:2], 2'b00};
            s_d.ext_long  = 1'b1;
            s_d.ext_burst = line_sz;
          end else begin
            // Unbuffered single access; odd word instruction fetch is word sized.
            s_d.state     = cif_pkg::ST_SINGLE;
            s_d.ext_req   = 1'b1;
            s_d.ext_addr  = LB.f_addr;
            s_d.ext_long  = LB.f_instr ? !LB.f_addr[1] : LB.f_long;
            s_d.ext_burst = 1'b0;
          end
        end
      end
      // One tag entry cleared per cycle until the last of the range.
      cif_pkg::ST_INVAL: begin
        clr_we = 1'b1;
        if (s_q.inv_cnt == s_q.inv_last) begin
          s_d.state = cif_pkg::ST_IDLE;
        end else begin
          s_d.inv_cnt = s_q.inv_cnt + 7'h01;
        end
      end
      // Each beat fills one buffer word; the missed word hits the next cycle.
      cif_pkg::ST_FILL: begin
        if (EXT_ACK) begin
          s_d.fb_data[s_q.ext_addr[3:2]] = EXT_RDATA;
          s_d.fb_vld[s_q.ext_addr[3:2]]  = 1'b1;
          if (s_q.beat == s_q.last_beat) begin
            s_d.state   = cif_pkg::ST_IDLE;
            s_d.ext_req = 1'b0;
          end else begin
            s_d.beat     = s_q.beat + 2'h1;
            s_d.ext_addr = {s_q.fb_line, s_q.crit + s_q.beat + 2'h1, 2'b00};
          end
        end
      end
      cif_pkg::ST_SINGLE: begin
        if (EXT_ACK) begin
          s_d.state   = cif_pkg::ST_IDLE;
          s_d.ext_req = 1'b0;
          s_d.done    = 1'b1;
          s_d.rdata   = EXT_RDATA;
        end
      end
      default: s_d.state = cif_pkg::ST_IDLE;
    endcase
    // Hits are served while idle or filling, never with a sweep pending.
    if ((s_q.state == cif_pkg::ST_IDLE || s_q.state == cif_pkg::ST_FILL) && !s_q.inv_pend
        && LB.f_req && !s_q.done && (hit_fb || hit_arr)) begin
      s_d.done  = 1'b1;
      s_d.rdata = hit_fb ? s_q.fb_data[LB.f_addr[3:2]] : data_mem[req_idx][LB.f_addr[3:2]];
      if (!hit_fb && req_idx == fb_idx) begin
        s_d.fb_mru = 1'b0;
      end
    end
  end

  // Control state; the arrays are deliberately left out of reset.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_q       <= '0;
      s_q.ctrl  <= `CIF_CTRL_RESET;
      s_q.state <= cif_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Array writes; a clear in the same cycle as a copy wins.
  always_ff @(posedge SYS_CLK) begin
    if (!SYS_RST && copy_we) begin
      tag_a[fb_idx]    <= s_q.fb_line[27:6];
      tag_v[fb_idx]    <= 1'b1;
      data_mem[fb_idx] <= s_q.fb_data;
    end
    if (!SYS_RST && clr_we) begin
      tag_v[clr_idx] <= 1'b0;
    end
    // Software supplies bit 10 itself to pick the half in split mode.
    if (!SYS_RST && LB.line_inv && !s_q.ctrl[`CIF_B_LINE_DIS]) begin
      tag_v[LB.line_addr[10:4]] <= 1'b0;
    end
  end

  // Outputs; control reads see zeros since every register is write-only.
  assign LB.ctl_rdata = 32'h0000_0000;
  assign LB.f_done    = s_q.done;
  assign LB.f_rdata   = s_q.rdata;
  assign LB.f_busy    = s_q.state == cif_pkg::ST_INVAL || s_q.inv_pend;
  assign EXT_REQ      = s_q.ext_req;
  assign EXT_ADDR     = s_q.ext_addr;
  assign EXT_LONG     = s_q.ext_long;
  assign EXT_BURST    = s_q.ext_burst;
endmodule : cif_cache
`default_nettype wire

// ==== src/cif_host.sv ====
// Purpose: Core-side end: turns AHB-Lite register writes into local bus work.
// Assumes: One outstanding fetch; slave answers with no wait states.
// Notes:   Coherency after code changes is software's job via line invalidate.
`timescale 1ns/1ps
`default_nettype none
`include "cif_params.svh"
module cif_host (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave.
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  // Local bus toward the cache.
  cif_if.host              LB
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cif_pkg::cif_host_t s_q, s_d;
  logic               aphase;
  logic [31:0]        status;

  // Register decode, command launch and fetch tracking.
  always_comb begin
    s_d          = s_q;
    s_d.ctl_wr   = 1'b0;
    s_d.line_inv = 1'b0;
    aphase       = HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2;
    status       = {30'h0, LB.f_busy, s_q.pend};
    s_d.dp_wr    = aphase && HWRITE;
    s_d.dp_addr  = HADDR[7:0];
    // Fetch answer, held until the next one.
    if (s_q.pend && LB.f_done) begin
      s_d.pend  = 1'b0;
      s_d.rdata = LB.f_rdata;
    end
    // Writes land in the data phase; unmapped offsets are ignored.
    if (s_q.dp_wr) begin
      case (s_q.dp_addr)
        `CIF_H_ADDR:  s_d.addr  = HWDATA;
        `CIF_H_WDATA: s_d.wdata = HWDATA;
        `CIF_H_ATTR:  s_d.attr  = HWDATA;
        `CIF_H_CMD: begin
          case (HWDATA[1:0])
            `CIF_OP_CTRL:  s_d.ctl_wr   = 1'b1;
            `CIF_OP_LINE:  s_d.line_inv = 1'b1;
            `CIF_OP_FETCH: s_d.pend     = !s_q.pend || s_d.pend;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // Read data is captured in the address phase for a zero-wait answer.
    s_d.hrdata = 32'h0000_0000;
    if (aphase && !HWRITE) begin
      case (HADDR[7:0])
        `CIF_H_ADDR:   s_d.hrdata = s_q.addr;
        `CIF_H_WDATA:  s_d.hrdata = s_q.wdata;
        `CIF_H_ATTR:   s_d.hrdata = s_q.attr;
        `CIF_H_STATUS: s_d.hrdata = status;
        `CIF_H_RDATA:  s_d.hrdata = s_q.rdata;
        default:       s_d.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs toward the bus and the cache.
  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;
  assign HRDATA       = s_q.hrdata;
  assign LB.ctl_wr    = s_q.ctl_wr;
  assign LB.ctl_code  = s_q.attr[27:16];
  assign LB.ctl_wdata = s_q.wdata;
  assign LB.ctl_super = s_q.attr[3];
  assign LB.line_inv  = s_q.line_inv;
  assign LB.line_addr = s_q.addr;
  assign LB.f_req     = s_q.pend;
  assign LB.f_addr    = s_q.addr;
  assign LB.f_instr   = s_q.attr[0];
  assign LB.f_long    = s_q.attr[1];
  assign LB.f_cache   = s_q.attr[2];
endmodule : cif_host
`default_nettype wire

// ==== src/cif_if.sv ====
// Purpose: Local bus between the core-side end and the cache end.
// Assumes: Both ends run on the same clock.
// Notes:   Control reads always return zero; the registers are write-only.
`timescale 1ns/1ps
`default_nettype none
interface cif_if;
  // Move-to-control access.
  logic        ctl_wr;
  logic [11:0] ctl_code;
  logic [31:0] ctl_wdata;
  logic        ctl_super;
  logic [31:0] ctl_rdata;
  // Single-line invalidate.
  logic        line_inv;
  logic [31:0] line_addr;
  // Fetch request and answer.
  logic        f_req;
  logic [31:0] f_addr;
  logic        f_instr;
  logic        f_long;
  logic        f_cache;
  logic        f_done;
  logic [31:0] f_rdata;
  logic        f_busy;
  modport dev  (input  ctl_wr, ctl_code, ctl_wdata, ctl_super, line_inv, line_addr,
                       f_req, f_addr, f_instr, f_long, f_cache,
                output ctl_rdata, f_done, f_rdata, f_busy);
  modport host (output ctl_wr, ctl_code, ctl_wdata, ctl_super, line_inv, line_addr,
                       f_req, f_addr, f_instr, f_long, f_cache,
                input  ctl_rdata, f_done, f_rdata, f_busy);
endinterface : cif_if
`default_nettype wire

// ==== src/cif_params.svh ====
// Purpose: Constants shared by the cache control end and the core-side end.
// Assumes: Control codes are the move-to-control register codes.
// Notes:   Host register offsets are byte addresses on AHB-Lite.
`ifndef CIF_PARAMS_SVH
`define CIF_PARAMS_SVH
// ----------------------------------------------------------------------
// Control codes and control register fields
// ----------------------------------------------------------------------
`define CIF_CODE_CTRL   12'h002
`define CIF_CODE_WIN0   12'h004
`define CIF_CODE_WIN1   12'h005
`define CIF_CTRL_RESET  32'h0000_0000
`define CIF_CTRL_MASK   32'h90f0_0403
`define CIF_B_ENABLE    31
`define CIF_B_LINE_DIS  28
`define CIF_B_INV_ALL   24
`define CIF_B_DIS_INSTR 23
`define CIF_B_DIS_DATA  22
`define CIF_B_INV_INSTR 21
`define CIF_B_INV_DATA  20
`define CIF_B_NC_BUF    10
`define CIF_B_FILL_HI   1
`define CIF_B_FILL_LO   0
// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define CIF_LAST_ENTRY  7'h7f
`define CIF_HALF_LAST   7'h3f
`define CIF_HALF_FIRST  7'h40
// ----------------------------------------------------------------------
// Core-side end register offsets
// ----------------------------------------------------------------------
`define CIF_H_CMD       8'h00
`define CIF_H_ADDR      8'h04
`define CIF_H_WDATA     8'h08
`define CIF_H_ATTR      8'h0c
`define CIF_H_STATUS    8'h10
`define CIF_H_RDATA     8'h14
`define CIF_OP_CTRL     2'h0
`define CIF_OP_LINE     2'h1
`define CIF_OP_FETCH    2'h2
`endif

// ==== src/cif_pkg.sv ====
// Purpose: Types of the cache control block.
// Assumes: Nothing beyond the constants header.
// Notes:   Each module keeps its registers in one packed struct; the cache arrays stand apart.
package cif_pkg;
  // ----------------------------------------------------------------------
  // Cache end
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_INVAL, ST_FILL, ST_SINGLE} cif_state_t;
  typedef struct packed {
    cif_state_t        state;
    logic [31:0]       ctrl;
    logic [31:0]       win0;
    logic [31:0]       win1;
    logic              inv_pend;
    logic [6:0]        inv_cnt;
    logic [6:0]        inv_last;
    logic [27:0]       fb_line;
    logic              fb_instr;
    logic              fb_nc;
    logic              fb_mru;
    logic [3:0]        fb_vld;
    logic [3:0][31:0]  fb_data;
    logic [1:0]        beat;
    logic [1:0]        last_beat;
    logic [1:0]        crit;
    logic              ext_req;
    logic [31:0]       ext_addr;
    logic              ext_long;
    logic              ext_burst;
    logic              done;
    logic [31:0]       rdata;
  } cif_dev_t;
  // ----------------------------------------------------------------------
  // Core-side end
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              dp_wr;
    logic [7:0]        dp_addr;
    logic [31:0]       addr;
    logic [31:0]       wdata;
    logic [31:0]       attr;
    logic [31:0]       rdata;
    logic              pend;
    logic              ctl_wr;
    logic              line_inv;
    logic [31:0]       hrdata;
  } cif_host_t;
endpackage : cif_pkg

// ==== verification/cif_asserts.sv ====
// Purpose: Checks on the local bus and external fetch wires.
// Assumes: One clock; checks off during reset.
// Notes:   Control is mirrored from supervisor writes.
`timescale 1ns/1ps
`default_nettype none
`include "cif_params.svh"
module cif_asserts (
  // Clock and reset.
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  // Local bus.
  input wire logic        ctl_wr,
  input wire logic [11:0] ctl_code,
  input wire logic [31:0] ctl_wdata,
  input wire logic        ctl_super,
  input wire logic [31:0] ctl_rdata,
  input wire logic        f_req,
  input wire logic [31:0] f_addr,
  input wire logic        f_instr,
  input wire logic        f_cache,
  input wire logic        f_done,
  input wire logic        f_busy,
  // External memory bus.
  input wire logic        EXT_REQ,
  input wire logic [31:0] EXT_ADDR,
  input wire logic        EXT_LONG,
  input wire logic        EXT_BURST,
  input wire logic        EXT_ACK
);
  logic [31:0] ctrl_q;
  logic [7:0]  blen_q;
  logic        half_q;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Control mirror and busy length; half sweeps only in split mode.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= 32'h0;
      half_q <= 1'b0;
    end else if (ctl_wr && ctl_super && ctl_code == `CIF_CODE_CTRL) begin
      ctrl_q <= ctl_wdata & `CIF_CTRL_MASK;
      half_q <= !ctl_wdata[23] && !ctl_wdata[22] && (ctl_wdata[21] ^ ctl_wdata[20]);
    end
    if (SYS_RST || !f_busy) blen_q <= 8'h0;
    else if (blen_q != 8'hff) blen_q <= blen_q + 8'h1;
  end
  sequence s_inv_req;
    ctl_wr && ctl_super && ctl_code == `CIF_CODE_CTRL && ctl_wdata[24];
  endsequence
  sequence s_beat_then_more;
    EXT_BURST && EXT_REQ && EXT_ACK ##1 EXT_REQ;
  endsequence
  a_rdata_zero: assert property (ctl_rdata == 32'h0)
    else $error("read data not zero");
  a_inv_starts: assert property (s_inv_req |=> f_busy)
    else $error("no busy after invalidate");
  a_inv_length: assert property ($fell(f_busy) |-> blen_q >= (half_q ? 8'd64 : 8'd128))
    else $error("sweep too short");
  a_busy_bounded: assert property ($rose(f_busy) |-> ##[1:400] !f_busy)
    else $error("sweep never ended");
  a_fetch_stalled: assert property (f_busy && $rose(f_req) |-> !f_done until !f_busy)
    else $error("fetch served while busy");
  a_no_spurious: assert property (ctl_wr && !f_busy && !(ctl_super
    && ctl_code == `CIF_CODE_CTRL && ctl_wdata[24]) |=> !f_busy)
    else $error("busy without request");
  a_crit_first: assert property (f_req && $rose(EXT_REQ) && EXT_BURST
    |-> EXT_ADDR[31:2] == f_addr[31:2])
    else $error("fill not critical first");
  a_burst_wrap: assert property (s_beat_then_more |-> EXT_ADDR ==
    {$past(EXT_ADDR[31:4]), $past(EXT_ADDR[3:2]) + 2'd1, 2'b00})
    else $error("beat order wrong");
  a_burst_long: assert property (EXT_REQ && EXT_BURST |-> EXT_LONG && EXT_ADDR[1:0] == 2'b00)
    else $error("beat not aligned longword");
  a_fill_size: assert property (ctrl_q[31] && !ctrl_q[23] && f_req && f_instr && f_cache
    && $rose(EXT_REQ) |-> EXT_BURST == !((ctrl_q[1:0] == 2'b00 && f_addr[3:2] == 2'b11)
    || (ctrl_q[1:0] == 2'b01 && f_addr[3])))
    else $error("fetch size wrong");
  a_data_line: assert property (ctrl_q[31] && !ctrl_q[22] && f_req && !f_instr && f_cache
    && $rose(EXT_REQ) |-> EXT_BURST)
    else $error("data miss not a line");
  a_disabled_one: assert property (!ctrl_q[31] && $rose(EXT_REQ) |-> !EXT_BURST
    && (!f_instr || EXT_LONG == !f_addr[1]))
    else $error("disabled fetch size wrong");
  a_nc_single: assert property (ctrl_q[31] && !ctrl_q[10] && f_req && f_instr && !f_cache
    && $rose(EXT_REQ) |-> !EXT_BURST)
    else $error("noncacheable burst");
endmodule : cif_asserts
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Drives AHB-Lite and serves external memory.
// Assumes: Each beat is acked after 1 to 4 idle cycles.
// Notes:   Beats are logged to check fetch size and order.
`timescale 1ns/1ps
`default_nettype none
`include "cif_params.svh"
module tb;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, ext_addr, ext_rdata, rd, a, b, c;
  logic        ext_req, ext_long, ext_burst, ext_ack;
  logic [33:0] beats[$];
  int          num_errors, compares, seed, nfall, busy_len, bcnt, dly, f0;
  cif_if lb();
  cif_host cif_host_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .LB(lb.host));
  cif_cache cif_cache_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LB(lb.dev),
    .EXT_REQ(ext_req), .EXT_ADDR(ext_addr), .EXT_LONG(ext_long), .EXT_BURST(ext_burst),
    .EXT_ACK(ext_ack), .EXT_RDATA(ext_rdata));
  cif_asserts cif_asserts_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .ctl_wr(lb.ctl_wr),
    .ctl_code(lb.ctl_code), .ctl_wdata(lb.ctl_wdata), .ctl_super(lb.ctl_super),
    .ctl_rdata(lb.ctl_rdata), .f_req(lb.f_req), .f_addr(lb.f_addr), .f_instr(lb.f_instr),
    .f_cache(lb.f_cache), .f_done(lb.f_done), .f_busy(lb.f_busy), .EXT_REQ(ext_req),
    .EXT_ADDR(ext_addr), .EXT_LONG(ext_long), .EXT_BURST(ext_burst), .EXT_ACK(ext_ack));
  // ----------------------------------------------------------------------
  // Memory, monitors and helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] mem(input logic [31:0] x);
    return {~x[15:2], 2'b01, x[15:2], 2'b10};
  endfunction
  function automatic int exp_nb(input int fs, input int w);
    return ((fs == 0 && w == 3) || (fs == 1 && w >= 2)) ? 1 : 4;
  endfunction
  function automatic logic [31:0] rnd_line();
    return $random(seed) & 32'hffff_fff0;
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Memory inverts its read data every cycle between beats.
  always @(posedge sys_clk) begin
    ext_ack <= ext_req && !ext_ack && dly == 0;
    ext_rdata <= ext_req && !ext_ack && dly == 0 ? mem(ext_addr) : ~ext_rdata;
    if (ext_req && !ext_ack) begin
      if (dly == 0) begin
        beats.push_back({ext_burst, ext_long, ext_addr});
        dly = $random(seed) & 3;
      end else dly = dly - 1;
    end
  end
  // Sweep length, counted on the busy flag.
  always @(posedge sys_clk) begin
    if (lb.f_busy === 1'b1) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      busy_len <= bcnt;
      nfall <= nfall + 1;
      bcnt <= 0;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic ctl(input logic [11:0] code, input logic [31:0] d, input logic sup);
    ahb(1'b1, `CIF_H_WDATA, d);
    ahb(1'b1, `CIF_H_ATTR, {4'h0, code, 12'h0, sup, 3'h0});
    ahb(1'b1, `CIF_H_CMD, {30'h0, `CIF_OP_CTRL});
  endtask : ctl
  task automatic inval(input logic [31:0] d, input int lo, input int hi);
    f0 = nfall;
    ctl(`CIF_CODE_CTRL, d, 1'b1);
    while (nfall == f0) @(posedge sys_clk);
    chk({31'h0, busy_len >= lo && busy_len <= hi}, 32'h1);
  endtask : inval
  // Fetch, wait out any line, then compare.
  task automatic fetch(input logic [31:0] x, input logic [3:0] at, input int nb, input logic lg);
    beats.delete();
    ahb(1'b1, `CIF_H_ADDR, x);
    ahb(1'b1, `CIF_H_ATTR, {28'h0, at});
    ahb(1'b1, `CIF_H_CMD, {30'h0, `CIF_OP_FETCH});
    do ahb(1'b0, `CIF_H_STATUS, 32'h0);
    while (rd[0] !== 1'b0);
    repeat (20) @(posedge sys_clk);
    ahb(1'b0, `CIF_H_RDATA, 32'h0);
    if (!x[1]) chk(rd, mem(x));
    chk(32'(beats.size()), 32'(nb));
    if (nb == 1) chk({30'h0, beats[0][33:32]}, {31'h0, lg});
    for (int k = 0; k < nb && nb == 4; k++)
      chk(beats[k][31:0], {x[31:4], 2'(x[3:2] + k), 2'b00});
  endtask : fetch
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 84902;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    ahb(1'b0, `CIF_H_STATUS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("test reset_regs done");
    ctl(`CIF_CODE_CTRL, 32'h8100_0000, 1'b0);
    ctl(12'h003, 32'h8100_0000, 1'b1);
    chk(32'(nfall), 32'h0);
    a = rnd_line();
    fetch(a, 4'he, 1, 1'b1);
    fetch(a | 32'h2, 4'hd, 1, 1'b0);
    ctl(`CIF_CODE_CTRL, 32'h0000_0400, 1'b1);
    fetch(a | 32'h4, 4'hd, 1, 1'b1);
    $display("test disabled done");
    f0 = nfall;
    ctl(`CIF_CODE_CTRL, 32'h8100_0002, 1'b1);
    fetch(rnd_line(), 4'hd, 4, 1'b1);
    chk(32'(nfall - f0), 32'h1);
    chk({31'h0, busy_len >= 128 && busy_len <= 136}, 32'h1);
    for (int fs = 0; fs < 4; fs++) begin
      ctl(`CIF_CODE_CTRL, 32'h8000_0000 | 32'(fs), 1'b1);
      for (int w = 0; w < 4; w++) begin
        fetch(rnd_line() | 32'(w << 2), 4'hd, exp_nb(fs, w), 1'b1);
        fetch(rnd_line() | 32'(w << 2), 4'he, 4, 1'b1);
      end
    end
    $display("test fill_size done");
    a = rnd_line();
    b = a ^ 32'h0000_0010;
    fetch(a, 4'hd, 4, 1'b1);
    fetch(a | 32'h8, 4'hd, 0, 1'b1);
    fetch(b, 4'hd, 4, 1'b1);
    fetch(a | 32'h4, 4'hd, 0, 1'b1);
    ahb(1'b1, `CIF_H_ADDR, a | 32'h400);
    ahb(1'b1, `CIF_H_CMD, {30'h0, `CIF_OP_LINE});
    fetch(a, 4'hd, 4, 1'b1);
    ctl(`CIF_CODE_CTRL, 32'h9000_0003, 1'b1);
    ahb(1'b1, `CIF_H_ADDR, b | 32'h400);
    ahb(1'b1, `CIF_H_CMD, {30'h0, `CIF_OP_LINE});
    fetch(b, 4'hd, 0, 1'b1);
    $display("test buffer_and_line done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    ahb(1'b0, `CIF_H_STATUS, 32'h0);
    chk(rd, 32'h0);
    fetch(b, 4'hd, 1, 1'b1);
    ctl(`CIF_CODE_CTRL, 32'h8000_0003, 1'b1);
    fetch(b | 32'h4, 4'hd, 0, 1'b1);
    $display("test second_reset done");
    c = rnd_line();
    ctl(`CIF_CODE_CTRL, 32'h8000_0002, 1'b1);
    fetch(c, 4'h9, 1, 1'b1);
    fetch(c | 32'h4, 4'h9, 1, 1'b1);
    ctl(`CIF_CODE_CTRL, 32'h8000_0402, 1'b1);
    fetch(c, 4'h9, 4, 1'b1);
    fetch(c | 32'h8, 4'h9, 0, 1'b1);
    fetch(rnd_line(), 4'hd, 4, 1'b1);
    fetch(c | 32'h4, 4'hd, 4, 1'b1);
    $display("test noncacheable done");
    inval(32'h0120_0000, 64, 72);
    inval(32'h0110_0000, 64, 72);
    inval(32'h0130_0000, 128, 136);
    inval(32'h01a0_0000, 128, 136);
    $display("test invalidate_halves done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
